// >>> logic/tsp_pkg.sv
// Package for the pulse output, pin capture and port-1 receive register block
package tsp_pkg;
  // Register offsets
  localparam logic [7:0] OFS_HIGH_PERIOD = 8'h85;
  localparam logic [7:0] OFS_LOW_PERIOD = 8'h86;
  localparam logic [7:0] OFS_QUANT_CORR = 8'h87;
  localparam logic [7:0] OFS_START_TIME = 8'h88;
  localparam logic [7:0] OFS_CAPT_LOW = 8'h89;
  localparam logic [7:0] OFS_CAPT_HIGH = 8'h8a;
  localparam logic [7:0] OFS_CAPT_FREERUN = 8'h8b;
  localparam logic [7:0] OFS_RX_HEAD_SIZE = 8'h90;
  localparam logic [7:0] OFS_RX_FIFO_DATA = 8'h91;
  localparam logic [7:0] OFS_RX_FRAMES = 8'ha0;
  localparam logic [7:0] OFS_RX_BCAST = 8'ha1;
  localparam logic [7:0] OFS_RX_MCAST = 8'ha2;
  localparam logic [7:0] OFS_RX_UCAST = 8'ha3;
  // Field layout and reset values
  localparam int QCORR_W = 8;
  localparam int SIZE_W = 11;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // Time base: 120 MHz tick derived from the 125 MHz system clock
  localparam int SYS_CLK_MHZ = 125;
  localparam int TC_CLK_MHZ = 120;
  localparam logic [7:0] DIV_INC = 8'(TC_CLK_MHZ);
  localparam logic [7:0] DIV_MOD = 8'(SYS_CLK_MHZ);
  localparam logic [31:0] TICK_NS = 32'h0000_0010;
  localparam int FIFO_DEPTH = 8;
  // Register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } tsp_reg_req_t;
  // One receive FIFO entry
  typedef struct packed {
    logic [SIZE_W-1:0] size;
    logic last;
    logic [31:0] data;
  } tsp_rx_word_t;
  // Per-frame statistics event
  typedef struct packed {
    logic done;
    logic bcast;
    logic mcast;
    logic ucast;
  } tsp_rx_stat_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_HIGH, ST_LOW} tsp_pulse_st_t;
endpackage

// >>> logic/tsp_regs.sv
// Receive FIFO and the pulse, capture and port-1 receive register block
//
// Contract
// R1: Time counters pace at 120 MHz, adding 16 ns per tick.
// R2: Host writes high period as multiple of 16, at least 16.
// R3: Host writes low period as multiple of 16, at least 16.
// R4: Correction 0..15 stretches each phase to trim period error.
// R5: Start-time write arms output; it begins when time reaches value.
// R6: Host writes start time of at least 16.
// R7: Stop halts toggling and returns pin to idle level.
// R8: Capture pin edge latches 64-bit time, low and high halves.
// R9: Same edge latches free-running counter.
// R10: Size field reports head frame length in bytes.
// R11: Host reads size register before frame data.
// R12: Data read returns and pops head FIFO word.
// R13: Bytes packed big-endian, first byte in top bits.
// R14: After frame end, no data until size read again.
// R15: Data register serves FIFO only in generic SPI mode.
// R16: Successive data reads pop successive words.
// R17: Frame counter counts every received frame.
// R18: Broadcast counter counts every broadcast frame.
// R19: Multicast counter counts every multicast frame.
// R20: Unicast counter counts unicast frames.
// R21: Stop control is a self-clearing strobe.
// R22: Idle level write acts only while output is not running. Code takes it only in ST_IDLE, not in ST_ARMED.
// R23: Enable low freezes time counters without clearing.
// R24: Statistics counters wrap and keep value on read.
// R25: Running output alternates high and low for programmed periods.
`timescale 1ns/1ps
module tsp_fifo #(
  parameter int W = 44,
  parameter int D = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0] wp;
    logic [AW:0] rp;
  } tsp_fifo_st_t;
  tsp_fifo_st_t st_q, st_d;
  logic full, empty;

  // Full and empty from pointer wrap bits
  assign empty = (st_q.wp == st_q.rp);
  assign full = (st_q.wp[AW-1:0] == st_q.rp[AW-1:0]) && (st_q.wp[AW] != st_q.rp[AW]);
  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = st_q.mem[st_q.rp[AW-1:0]];

  // Pointer and storage update
  always_comb begin
    st_d = st_q;
    if (i_in_valid && !full) begin
      st_d.mem[st_q.wp[AW-1:0]] = i_in_data;
      st_d.wp = st_q.wp + 1'b1;
    end
    if (i_out_ready && !empty) begin
      st_d.rp = st_q.rp + 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule

module tsp_regs
  import tsp_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire tsp_reg_req_t i_reg,
  output logic [31:0] o_reg_rdata,
  input wire logic i_time_counter_enable,
  input wire logic i_pulse_stop_control,
  input wire logic i_pulse_idle_level_wr,
  input wire logic i_pulse_idle_level,
  input wire logic i_generic_spi_mode,
  input wire logic i_capture_input_pin,
  output logic o_pulse_timer_output,
  input wire logic i_rx_valid,
  output logic o_rx_ready,
  input wire tsp_rx_word_t i_rx_word,
  input wire tsp_rx_stat_t i_rx_stat
);
  typedef struct packed {
    logic [7:0] div;
    logic [63:0] time_ns;
    logic [31:0] freerun;
    logic [31:0] high_period;
    logic [31:0] low_period;
    logic [QCORR_W-1:0] quant_corr;
    logic [31:0] start_time;
    logic [63:0] captured_time;
    logic [31:0] captured_freerun;
    logic pin_prev;
    tsp_pulse_st_t pst;
    logic [31:0] phase;
    logic idle_level;
    logic pin_out;
    logic gate;
    logic [31:0] rdata;
    logic [31:0] cnt_frames;
    logic [31:0] cnt_bcast;
    logic [31:0] cnt_mcast;
    logic [31:0] cnt_ucast;
  } tsp_regs_st_t;
  tsp_regs_st_t st_q, st_d;

  logic tick;
  logic run;
  logic [8:0] div_sum;
  logic [31:0] phase_next;
  logic [31:0] phase_target;
  logic head_valid;
  tsp_rx_word_t head;
  logic pop;
  logic capture;

  // Receive FIFO between MAC side and register readout
  tsp_fifo #(
    .W($bits(tsp_rx_word_t)),
    .D(FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_in_valid(i_rx_valid),
    .o_in_ready(o_rx_ready),
    .i_in_data(i_rx_word),
    .o_out_valid(head_valid),
    .i_out_ready(pop),
    .o_out_data(head)
  );

  // Fractional divider for the 120 MHz time tick
  assign div_sum = {1'b0, st_q.div} + {1'b0, DIV_INC};
  assign tick = (div_sum >= {1'b0, DIV_MOD}); // R1
  assign run = tick && i_time_counter_enable; // R23
  assign phase_next = st_q.phase + TICK_NS;
  assign capture = i_capture_input_pin && !st_q.pin_prev;
  // Pop only for an opened frame in generic mode
  assign pop = i_reg.rd && (i_reg.addr == OFS_RX_FIFO_DATA) && i_generic_spi_mode
               && st_q.gate && head_valid; // R12 R15 R16

  // Phase length including quantisation correction
  always_comb begin
    if (st_q.pst == ST_HIGH) begin
      phase_target = st_q.high_period + 32'(st_q.quant_corr); // R4
    end else begin
      phase_target = st_q.low_period + 32'(st_q.quant_corr); // R4
    end
  end

  // Next state of the whole block
  always_comb begin
    st_d = st_q;
    // Time base
    if (tick) begin
      st_d.div = 8'(div_sum - {1'b0, DIV_MOD});
    end else begin
      st_d.div = div_sum[7:0];
    end
    if (run) begin
      st_d.time_ns = st_q.time_ns + 64'(TICK_NS); // R1 R23
      st_d.freerun = st_q.freerun + 32'h0000_0001; // R23
    end
    // Pin capture
    st_d.pin_prev = i_capture_input_pin;
    if (capture) begin
      st_d.captured_time = st_q.time_ns; // R8
      st_d.captured_freerun = st_q.freerun; // R9
    end
    // Register writes
    if (i_reg.wr) begin
      if (i_reg.addr == OFS_HIGH_PERIOD) begin
        st_d.high_period = i_reg.wdata;
      end else if (i_reg.addr == OFS_LOW_PERIOD) begin
        st_d.low_period = i_reg.wdata;
      end else if (i_reg.addr == OFS_QUANT_CORR) begin
        st_d.quant_corr = i_reg.wdata[QCORR_W-1:0];
      end else if (i_reg.addr == OFS_START_TIME) begin
        st_d.start_time = i_reg.wdata;
      end
    end
    // Pulse output sequencer
    case (st_q.pst)
      ST_IDLE: begin
        if (i_pulse_idle_level_wr) begin
          st_d.idle_level = i_pulse_idle_level; // R22
        end
      end
      ST_ARMED: begin
        if (run && (st_q.time_ns[31:0] >= st_q.start_time)) begin
          st_d.pst = ST_HIGH; // R5
          st_d.phase = RST_WORD;
        end
      end
      ST_HIGH: begin
        if (run) begin
          st_d.phase = phase_next;
          if (phase_next >= phase_target) begin
            st_d.pst = ST_LOW; // R25
            st_d.phase = RST_WORD;
          end
        end
      end
      default: begin
        if (run) begin
          st_d.phase = phase_next;
          if (phase_next >= phase_target) begin
            st_d.pst = ST_HIGH; // R25
            st_d.phase = RST_WORD;
          end
        end
      end
    endcase
    if (i_reg.wr && (i_reg.addr == OFS_START_TIME)) begin
      st_d.pst = ST_ARMED; // R5
      st_d.phase = RST_WORD;
    end
    // Stop strobe is not stored, so it acts only in the cycle it is high
    if (i_pulse_stop_control) begin
      st_d.pst = ST_IDLE; // R7 R21
      st_d.phase = RST_WORD;
    end
    if (st_d.pst == ST_HIGH) begin
      st_d.pin_out = 1'b1;
    end else if (st_d.pst == ST_LOW) begin
      st_d.pin_out = 1'b0;
    end else begin
      st_d.pin_out = st_d.idle_level; // R7 R22
    end
    // Frame gate for the data register
    if (pop && head.last) begin
      st_d.gate = 1'b0; // R14
    end
    if (i_reg.rd && (i_reg.addr == OFS_RX_HEAD_SIZE) && i_generic_spi_mode) begin
      st_d.gate = 1'b1; // R11 R14
    end
    // Statistics counters, wrapping
    if (i_rx_stat.done) begin
      st_d.cnt_frames = st_q.cnt_frames + 32'h0000_0001; // R17 R24
      if (i_rx_stat.bcast) begin
        st_d.cnt_bcast = st_q.cnt_bcast + 32'h0000_0001; // R18 R24
      end
      if (i_rx_stat.mcast) begin
        st_d.cnt_mcast = st_q.cnt_mcast + 32'h0000_0001; // R19 R24
      end
      if (i_rx_stat.ucast) begin
        st_d.cnt_ucast = st_q.cnt_ucast + 32'h0000_0001; // R20 R24
      end
    end
    // Read data, registered
    if (i_reg.rd) begin
      if (i_reg.addr == OFS_HIGH_PERIOD) begin
        st_d.rdata = st_q.high_period;
      end else if (i_reg.addr == OFS_LOW_PERIOD) begin
        st_d.rdata = st_q.low_period;
      end else if (i_reg.addr == OFS_QUANT_CORR) begin
        st_d.rdata = 32'(st_q.quant_corr);
      end else if (i_reg.addr == OFS_START_TIME) begin
        st_d.rdata = st_q.start_time;
      end else if (i_reg.addr == OFS_CAPT_LOW) begin
        st_d.rdata = st_q.captured_time[31:0]; // R8
      end else if (i_reg.addr == OFS_CAPT_HIGH) begin
        st_d.rdata = st_q.captured_time[63:32]; // R8
      end else if (i_reg.addr == OFS_CAPT_FREERUN) begin
        st_d.rdata = st_q.captured_freerun; // R9
      end else if (i_reg.addr == OFS_RX_HEAD_SIZE) begin
        st_d.rdata = head_valid ? 32'(head.size) : RST_WORD; // R10
      end else if (i_reg.addr == OFS_RX_FIFO_DATA) begin
        st_d.rdata = pop ? head.data : RST_WORD; // R13 R15
      end else if (i_reg.addr == OFS_RX_FRAMES) begin
        st_d.rdata = st_q.cnt_frames;
      end else if (i_reg.addr == OFS_RX_BCAST) begin
        st_d.rdata = st_q.cnt_bcast;
      end else if (i_reg.addr == OFS_RX_MCAST) begin
        st_d.rdata = st_q.cnt_mcast;
      end else if (i_reg.addr == OFS_RX_UCAST) begin
        st_d.rdata = st_q.cnt_ucast;
      end else begin
        st_d.rdata = RST_WORD;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= '0;
      st_q.pst <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_reg_rdata = st_q.rdata;
  assign o_pulse_timer_output = st_q.pin_out;

  // Checks beside the logic
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  AST_TIME_STEP: assert property (run |=> st_q.time_ns == $past(st_q.time_ns) + 64'h10) // R1
    else $error("time counter did not add 16");
  AST_TIME_FREEZE: assert property (!i_time_counter_enable |=> $stable(st_q.time_ns)) // R23
    else $error("time counter moved while disabled");
  AST_TICK_RATE: assert property (!tick |=> tick) // R1
    else $error("two idle cycles in 120 MHz divider");
  AST_START_ARM: assert property (i_reg.wr && i_reg.addr == OFS_START_TIME
    && !i_pulse_stop_control |=> st_q.pst == ST_ARMED) // R5
    else $error("start write did not arm output");
  AST_STOP_IDLE: assert property (i_pulse_stop_control |=>
    st_q.pst == ST_IDLE && o_pulse_timer_output == st_q.idle_level) // R7
    else $error("stop did not restore idle level");
  AST_IDLE_LOCK: assert property (st_q.pst != ST_IDLE |=> $stable(st_q.idle_level)) // R22
    else $error("idle level changed while running");
  AST_CAPTURE: assert property (capture |=> st_q.captured_time == $past(st_q.time_ns)
    && st_q.captured_freerun == $past(st_q.freerun)) // R8
    else $error("capture missed time value");
  AST_GATE_CLOSE: assert property (pop && head.last |=> !st_q.gate) // R14
    else $error("gate still open after frame end");
  AST_NO_POP_MODE: assert property (!i_generic_spi_mode && i_reg.rd
    && i_reg.addr == OFS_RX_FIFO_DATA |=> o_reg_rdata == RST_WORD) // R15
    else $error("fifo data returned outside generic mode");
  AST_DATA_ZERO: assert property (i_reg.rd && i_reg.addr == OFS_RX_FIFO_DATA && !st_q.gate
    |=> o_reg_rdata == RST_WORD) // R14
    else $error("data returned without size read");
  AST_FRAME_CNT: assert property (i_rx_stat.done |=>
    st_q.cnt_frames == $past(st_q.cnt_frames) + 32'h1) // R17
    else $error("frame counter did not count");
  AST_HIGH_LEN: assert property (st_q.pst == ST_HIGH && run && phase_next >= phase_target
    && !i_pulse_stop_control && !i_reg.wr |=> st_q.pst == ST_LOW) // R25
    else $error("high phase overran its period");
  AST_LOW_LEN: assert property (st_q.pst == ST_LOW && run && phase_next >= phase_target
    && !i_pulse_stop_control && !i_reg.wr |=> st_q.pst == ST_HIGH) // R25
    else $error("low phase overran its period");

  // Counters, readout and idle level checks
  AST_BCAST_CNT: assert property (i_rx_stat.done && i_rx_stat.bcast |=>
    st_q.cnt_bcast == $past(st_q.cnt_bcast) + 32'h1) // R18
    else $error("broadcast counter did not count");
  AST_MCAST_CNT: assert property (i_rx_stat.done && i_rx_stat.mcast |=>
    st_q.cnt_mcast == $past(st_q.cnt_mcast) + 32'h1) // R19
    else $error("multicast counter did not count");
  AST_UCAST_CNT: assert property (i_rx_stat.done && i_rx_stat.ucast |=>
    st_q.cnt_ucast == $past(st_q.cnt_ucast) + 32'h1) // R20
    else $error("unicast counter did not count");
  AST_POP_DATA: assert property (pop |=>
    o_reg_rdata == $past(head.data)) // R12
    else $error("popped word not returned");
  AST_SIZE_READ: assert property (i_reg.rd && i_reg.addr == OFS_RX_HEAD_SIZE && head_valid
    |=> o_reg_rdata == 32'($past(head.size))) // R10
    else $error("size read did not return head frame size");
  AST_IDLE_PIN: assert property (st_q.pst == ST_IDLE && i_pulse_idle_level_wr
    && !(i_reg.wr && i_reg.addr == OFS_START_TIME) |=> o_pulse_timer_output == $past(i_pulse_idle_level)) // R22
    else $error("idle level write did not reach the pin");

  COV_CAPTURE: cover property (capture);
  COV_TOGGLE: cover property (st_q.pst == ST_HIGH ##1 st_q.pst == ST_LOW);
  COV_FRAME_END: cover property (pop && head.last);
  COV_FIFO_FULL: cover property (!o_rx_ready);
endmodule

// >>> verif/tsp_regs_test.sv
// Register, capture, receive FIFO and pulse output tests of the register block
`timescale 1ns/1ps
module tsp_regs_test
  import tsp_pkg::*;
;
  logic clk, rst_n, en, stop, idle_wr, idle, mode, capt, pout, rx_valid, rx_ready;
  logic [31:0] rdata;
  tsp_reg_req_t req;
  tsp_rx_word_t rx_word;
  tsp_rx_stat_t rx_stat;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  logic [7:0] ofs[13] = '{8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8a, 8'h8b, 8'h90, 8'h91,
    8'ha0, 8'ha1, 8'ha2, 8'ha3};

  tsp_regs dut_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_reg(req), .o_reg_rdata(rdata),
    .i_time_counter_enable(en), .i_pulse_stop_control(stop), .i_pulse_idle_level_wr(idle_wr),
    .i_pulse_idle_level(idle), .i_generic_spi_mode(mode), .i_capture_input_pin(capt),
    .o_pulse_timer_output(pout), .i_rx_valid(rx_valid), .o_rx_ready(rx_ready),
    .i_rx_word(rx_word), .i_rx_stat(rx_stat));
  tsp_rx_src src_u (.i_clk_sys(clk), .i_rx_ready(rx_ready), .o_rx_valid(rx_valid),
    .o_rx_word(rx_word), .o_rx_stat(rx_stat));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle register requests, data taken the cycle after
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(negedge clk);
    req.rd = 1'b0;
    q = rdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    rd(a, q);
    chk(q, e);
  endtask

  task automatic capture(output logic [31:0] f);
    capt = 1'b1;
    @(negedge clk);
    capt = 1'b0;
    rd(8'h8b, f);
  endtask

  // Expected big-endian word w of a source frame of nb bytes
  function automatic logic [31:0] ew(input int nb, input int w);
    for (int k = 0; k < 4; k++) ew[31-8*k -: 8] = (4*w+k < nb) ? 8'(4*w+k) + 8'h11 : 8'h00;
  endfunction

  // Main sequence
  initial begin
    logic [31:0] f, g;
    int n, hc, lc;
    req = '0;
    {en, stop, idle_wr, idle, capt} = 5'h00;
    mode = 1'b0;
    rst_n = 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    foreach (ofs[i]) rdc(ofs[i], 32'h0);
    mode = 1'b1;
    wr(8'h85, 32'h0000_0020);
    wr(8'h86, 32'h0000_0030);
    wr(8'h87, 32'hffff_ff0f);
    wr(8'h89, 32'h0000_dead);
    rdc(8'h85, 32'h0000_0020);
    rdc(8'h86, 32'h0000_0030);
    rdc(8'h87, 32'h0000_000f);
    rdc(8'h89, 32'h0);
    rdc(8'h80, 32'h0);
    fork src_u.send(10, 3'b100); join_none
    repeat (8) @(negedge clk);
    rdc(8'h91, 32'h0);
    rdc(8'h90, 32'd10);
    for (n = 0; n < 3; n++) rdc(8'h91, ew(10, n));
    rdc(8'h91, 32'h0);
    fork src_u.send(40, 3'b010); join_none
    repeat (14) @(negedge clk);
    chk({31'h0, rx_ready}, 32'h0);
    rdc(8'h90, 32'd40);
    for (n = 0; n < 10; n++) rdc(8'h91, ew(40, n));
    rdc(8'h91, 32'h0);
    mode = 1'b0;
    fork src_u.send(8, 3'b001); join_none
    repeat (6) @(negedge clk);
    rdc(8'h90, 32'd8);
    rdc(8'h91, 32'h0);
    mode = 1'b1;
    rdc(8'h90, 32'd8);
    rdc(8'h91, ew(8, 0));
    rdc(8'h91, ew(8, 1));
    repeat (4) @(negedge clk);
    rdc(8'ha0, 32'd3);
    rdc(8'ha1, 32'd1);
    rdc(8'ha2, 32'd1);
    rdc(8'ha3, 32'd1);
    rdc(8'ha0, 32'd3);
    en = 1'b1;
    repeat (50) @(negedge clk);
    capture(f);
    rdc(8'h89, {f[27:0], 4'h0});
    rdc(8'h8a, 32'h0);
    chk({31'h0, f > 32'd40}, 32'h1);
    en = 1'b0;
    capture(f);
    repeat (20) @(negedge clk);
    capture(g);
    chk(g, f);
    en = 1'b1;
    // Two correction values: phases last period plus correction, in 16 ns ticks
    for (n = 0; n < 2; n++) begin
      wr(8'h87, n ? 32'd15 : 32'd0);
      wr(8'h88, 32'd16);
      hc = 0;
      while (pout !== 1'b1 && hc < 100) begin
        @(negedge clk);
        hc++;
      end
      hc = 0;
      while (pout === 1'b1 && hc < 100) begin
        @(negedge clk);
        hc++;
      end
      lc = 0;
      while (pout === 1'b0 && lc < 100) begin
        @(negedge clk);
        lc++;
      end
      chk({31'h0, hc == 2 + n || hc == 3 + n}, 32'h1);
      chk({31'h0, lc == 3 + n || lc == 4 + n}, 32'h1);
      stop = 1'b1;
      @(negedge clk);
      stop = 1'b0;
      @(negedge clk);
      chk({31'h0, pout}, 32'h0);
      repeat (10) @(negedge clk);
      chk({31'h0, pout}, 32'h0);
    end
    idle = 1'b1;
    idle_wr = 1'b1;
    @(negedge clk);
    idle_wr = 1'b0;
    @(negedge clk);
    chk({31'h0, pout}, 32'h1);
    complete_run();
  end
endmodule

// >>> verif/tsp_rx_src.sv
// Port-1 receive frame source feeding the register block FIFO
`timescale 1ns/1ps
module tsp_rx_src
  import tsp_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rx_ready,
  output logic o_rx_valid,
  output tsp_rx_word_t o_rx_word,
  output tsp_rx_stat_t o_rx_stat
);
  // Idle outputs at time zero
  initial begin
    o_rx_valid = 1'b0;
    o_rx_word = '0;
    o_rx_stat = '0;
  end

  // One frame word by word, stalling while the FIFO refuses, then its stats pulse
  task automatic send(input int nb, input logic [2:0] kind);
    logic [31:0] d;
    for (int w = 0; w < (nb + 3) / 4; w++) begin
      for (int k = 0; k < 4; k++) d[31-8*k -: 8] = (4*w+k < nb) ? 8'(4*w+k) + 8'h11 : 8'h00;
      @(negedge i_clk_sys);
      o_rx_valid = 1'b1;
      o_rx_word = '{size: 11'(nb), last: (w == (nb + 3) / 4 - 1), data: d};
      while (i_rx_ready !== 1'b1) @(negedge i_clk_sys);
      @(posedge i_clk_sys);
    end
    @(negedge i_clk_sys);
    o_rx_valid = 1'b0;
    o_rx_word.data = ~o_rx_word.data; // Stale data never looks valid
    o_rx_stat = {1'b1, kind};
    @(negedge i_clk_sys);
    o_rx_stat = '0;
  endtask
endmodule
